// [hdl/lane_deskew_marker_config.sv]
/*
 Lane deskew selection, lane marker control, channel-sync code and
 low-speed transmit buffer of the link aggregator, with their registers.
 Assumes register requests and lane marker sightings come from logic on
 clk_i, one request per cycle, with reads answered a cycle later.
*/
`timescale 1ns/1ps
`include "lane_deskew_defines.svh"

module lane_tx_buffer #(
   parameter int W     = 10,
   parameter int DEPTH = `BUFFER_DEPTH,
   parameter int CW    = $clog2(DEPTH + 1)
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic [CW-1:0] limit_i,
   input  wire logic [CW-1:0] mark_i,
   input  wire logic          in_valid_i,
   output logic               in_ready_o,
   input  wire logic [W-1:0]  in_data_i,
   output logic               out_valid_o,
   input  wire logic          out_ready_i,
   output logic [W-1:0]       out_data_o,
   output logic               watermark_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [CW-1:0]           cnt;
      logic                    in_ready;
      logic                    out_valid;
      logic                    wmk;
      logic [W-1:0]            dout;
   } buf_state_t;
   buf_state_t s;
   buf_state_t next_s;
   logic       push;
   logic       pop;
   assign push = in_valid_i & s.in_ready;
   assign pop  = out_ready_i & s.out_valid;
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wp] = in_data_i;
         next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + AW'(1);
      end
      if (pop) begin
         next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + AW'(1);
      end
      next_s.cnt = s.cnt + CW'(push) - CW'(pop);
      // Ready is registered, so it looks at the next count to stay honest
      next_s.in_ready  = next_s.cnt < limit_i;
      next_s.out_valid = next_s.cnt != '0;
      next_s.wmk       = next_s.cnt >= mark_i;
      next_s.dout      = next_s.mem[next_s.rp];
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign in_ready_o  = s.in_ready;
   assign out_valid_o = s.out_valid;
   assign out_data_o  = s.dout;
   assign watermark_o = s.wmk;
   buffer_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.cnt >= limit_i) |-> !in_ready_o)
      else $error("buffer accepts data beyond its depth limit");

endmodule : lane_tx_buffer

module lane_deskew_marker_config #(
   parameter int          W          = 10,
   parameter int          DEPTH      = `BUFFER_DEPTH,
   parameter logic [9:0]  BASE_SYNC  = 10'h017C
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  lane_deskew_pkg::reg_req_t     reg_req_i,
   output logic [15:0]                   reg_rdata_o,
   input  wire logic [3:0][3:0]          marker_seen_i,
   input  wire logic                     low_speed_marker_enable_i,
   input  wire logic                     low_speed_signal_loss_enable_i,
   input  wire logic                     rx_bitwise_interleave_i,
   output logic [7:0]                    marker_lane_o,
   output logic [31:0]                   marker_crc_o,
   output logic                          rx_marker_detect_active_o,
   output logic [2:0]                    rx_marker_sel_o,
   output logic [9:0]                    sync_code_o,
   input  wire logic                     tx_valid_i,
   output logic                          tx_ready_o,
   input  wire logic [W-1:0]             tx_data_i,
   output logic                          lane_valid_o,
   input  wire logic                     lane_ready_i,
   output logic [W-1:0]                  lane_data_o,
   output logic                          tx_watermark_o
);
   import lane_deskew_pkg::*;
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [15:0]           lane_deskew_groups;
      logic [15:0]           hs_marker_gen_ctrl;
      logic [15:0]           rx_marker_detect_ctrl;
      logic [15:0]           ls_tx_buffer_ctrl;
      logic [3:0]            align_status;
      logic [3:0][1:0][3:0]  seen;
      logic [3:0][1:0][2:0]  skew_cnt;
      logic [15:0]           rdata;
      logic [7:0]            marker_lane;
      logic [31:0]           crc;
      logic                  detect_active;
      logic [2:0]            rx_sel;
      logic [9:0]            sync_code;
   } cfg_state_t;

   cfg_state_t s;
   cfg_state_t next_s;
   logic [CW-1:0] limit;
   logic [CW-1:0] mark;
   logic [2:0]    depth_sel;
   logic [1:0]    wmk_sel;

   function automatic lane_sets_t decode_sets(input logic [2:0] code);
      lane_sets_t d;
      d = '0;
      unique case (code)
         3'b000: d = '0;
         3'b001: d.set_a = 4'h3;
         3'b010: d.set_a = 4'h7;
         3'b011, 3'b111: d.set_a = 4'hF;
         3'b100: d.set_a = 4'hC;
         3'b101: d = '{set_b: 4'hC, set_a: 4'h3};
         3'b110: d = '0;
      endcase
      return d;
   endfunction : decode_sets

   // Unit order: tx lower, tx upper, rx lower, rx upper (status bits 8..11)
   function automatic logic [2:0] unit_sel(input logic [15:0] r, input int u);
      logic [2:0] v;
      v = 3'h0;
      unique case (u)
         0: v = r[`POS_TX_LOWER_SEL +: 3];
         1: v = r[`POS_TX_UPPER_SEL +: 3];
         2: v = r[`POS_RX_LOWER_SEL +: 3];
         default: v = r[`POS_RX_UPPER_SEL +: 3];
      endcase
      return v;
   endfunction : unit_sel

   always_comb begin
      lane_sets_t sets;
      logic [3:0] m;
      logic [3:0] hit;
      logic [3:0] got;
      logic       gen;
      sets   = '0;
      m      = '0;
      hit    = '0;
      got    = '0;
      gen    = 1'b0;
      next_s = s;
      // A read clears status; a new alignment in the same cycle still sets it
      if (reg_req_i.rd && reg_req_i.addr == `ADDR_ALIGN_STATUS) begin
         next_s.align_status = '0;
      end
      for (int u = 0; u < 4; u++) begin
         sets = decode_sets(unit_sel(s.lane_deskew_groups, u));
         for (int k = 0; k < 2; k++) begin
            m   = k[0] ? sets.set_b : sets.set_a;
            hit = marker_seen_i[u] & m;
            got = s.seen[u][k] | hit;
            if (m == 4'h0) begin
               next_s.seen[u][k]     = '0;
               next_s.skew_cnt[u][k] = '0;
            end else if (got == m) begin
               next_s.align_status[u] = 1'b1;
               next_s.seen[u][k]      = '0;
               next_s.skew_cnt[u][k]  = '0;
            end else if (s.skew_cnt[u][k] >= `MAX_SKEW_BYTES) begin
               // Skew beyond four bytes: restart from this cycle's sightings
               next_s.seen[u][k]     = hit;
               next_s.skew_cnt[u][k] = '0;
            end else begin
               next_s.seen[u][k]     = got;
               next_s.skew_cnt[u][k] = (got != 4'h0) ? s.skew_cnt[u][k] + 3'h1 : 3'h0;
            end
         end
      end
      if (reg_req_i.wr) begin
         unique case (reg_req_i.addr)
            `ADDR_DESKEW_GROUPS:
               next_s.lane_deskew_groups = reg_req_i.wdata & `DESKEW_WR_MASK;
            `ADDR_MARKER_GEN: next_s.hs_marker_gen_ctrl = reg_req_i.wdata;
            `ADDR_RX_MARKER:  next_s.rx_marker_detect_ctrl = reg_req_i.wdata;
            `ADDR_TX_BUFFER:  next_s.ls_tx_buffer_ctrl = reg_req_i.wdata;
            default: ;
         endcase
         if (reg_req_i.addr == `ADDR_DESKEW_GROUPS) begin
            next_s.seen     = '0;
            next_s.skew_cnt = '0;
         end
      end
      if (reg_req_i.rd) begin
         unique case (reg_req_i.addr)
            `ADDR_DESKEW_GROUPS: next_s.rdata = s.lane_deskew_groups;
            `ADDR_MARKER_GEN:    next_s.rdata = s.hs_marker_gen_ctrl;
            `ADDR_RX_MARKER:     next_s.rdata = s.rx_marker_detect_ctrl;
            `ADDR_TX_BUFFER:     next_s.rdata = s.ls_tx_buffer_ctrl;
            `ADDR_ALIGN_STATUS:
               next_s.rdata = {4'h0, s.align_status, 8'h00};
            default: next_s.rdata = 16'h0000;
         endcase
      end
      gen = s.hs_marker_gen_ctrl[`POS_MARKER_ENABLE]
          | (low_speed_marker_enable_i & low_speed_signal_loss_enable_i);
      next_s.marker_lane = gen ? 8'h01 << s.hs_marker_gen_ctrl[`POS_MARKER_SEL +: 3]
                               : 8'h00;
      next_s.crc = `MARKER_CRC_VALUE;
      next_s.detect_active = s.rx_marker_detect_ctrl[`POS_MARKER_ENABLE]
                           & rx_bitwise_interleave_i;
      next_s.rx_sel = s.rx_marker_detect_ctrl[`POS_MARKER_SEL +: 3];
      next_s.sync_code = s.ls_tx_buffer_ctrl[`POS_SYNC_OVERRIDE]
                       ? s.ls_tx_buffer_ctrl[9:0] : BASE_SYNC;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.lane_deskew_groups    <= `RST_DESKEW_GROUPS;
         s.hs_marker_gen_ctrl    <= `RST_MARKER_GEN;
         s.rx_marker_detect_ctrl <= `RST_RX_MARKER;
         s.ls_tx_buffer_ctrl     <= `RST_TX_BUFFER;
         s.crc                   <= `MARKER_CRC_VALUE;
         s.sync_code             <= BASE_SYNC;
      end else begin
         s <= next_s;
      end
   end

   // Depth code 0 means the full buffer; codes 1..7 cap the fill level
   assign depth_sel = s.ls_tx_buffer_ctrl[`POS_DEPTH_SEL +: 3];
   assign wmk_sel   = s.ls_tx_buffer_ctrl[`POS_WATERMARK_SEL +: 2];
   assign limit = (depth_sel == 3'h0 || CW'(depth_sel) > CW'(DEPTH))
                ? CW'(DEPTH) : CW'(depth_sel);
   assign mark  = CW'((32'(wmk_sel) + 32'd1) * 32'(DEPTH) / 32'd4);

   lane_tx_buffer #(
      .W     (W),
      .DEPTH (DEPTH),
      .CW    (CW)
   ) u_buffer (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .limit_i     (limit),
      .mark_i      (mark),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .in_data_i   (tx_data_i),
      .out_valid_o (lane_valid_o),
      .out_ready_i (lane_ready_i),
      .out_data_o  (lane_data_o),
      .watermark_o (tx_watermark_o)
   );

   assign reg_rdata_o               = s.rdata;
   assign marker_lane_o             = s.marker_lane;
   assign marker_crc_o              = s.crc;
   assign rx_marker_detect_active_o = s.detect_active;
   assign rx_marker_sel_o           = s.rx_sel;
   assign sync_code_o               = s.sync_code;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence all_upper_rx_seen;
      s.lane_deskew_groups[14:12] == 3'b011 && marker_seen_i[3] == 4'hF;
   endsequence
   sequence no_status_read;
      !(reg_req_i.rd && reg_req_i.addr == `ADDR_ALIGN_STATUS);
   endsequence

   reset_values_a: assert property ($past(rst_i) |->
      s.lane_deskew_groups == 16'h0000 && s.rx_marker_detect_ctrl == 16'h0CC8
      && s.hs_marker_gen_ctrl == 16'h02BC)
      else $error("registers not at reset values after reset");
   upper_rx_align_a: assert property (all_upper_rx_seen |=> s.align_status[3])
      else $error("full upper receive group did not align");
   status_held_a: assert property ((s.align_status[0] ##0 no_status_read)
      |=> s.align_status[0])
      else $error("alignment status dropped without a read");
   reserved_code_a: assert property ((s.lane_deskew_groups[2:0] == 3'b110)
      |=> !$rose(s.align_status[0]))
      else $error("reserved code produced alignment");
   marker_lane_a: assert property (s.hs_marker_gen_ctrl[11]
      |=> marker_lane_o == (8'h01 << $past(s.hs_marker_gen_ctrl[14:12])))
      else $error("marker not on selected lane");
   marker_crc_a: assert property (marker_lane_o != 8'h00
      |-> marker_crc_o == 32'hFE00_00FE)
      else $error("marker CRC not forced");
   loss_marker_a: assert property ((low_speed_marker_enable_i
      && low_speed_signal_loss_enable_i) |=> marker_lane_o != 8'h00)
      else $error("marker missing with marker and loss enables");
   detect_gate_a: assert property (!$past(rst_i) |-> rx_marker_detect_active_o ==
      ($past(s.rx_marker_detect_ctrl[11]) && $past(rx_bitwise_interleave_i)))
      else $error("marker detection not gated by interleave");
   sync_code_a: assert property (s.ls_tx_buffer_ctrl[10]
      |=> sync_code_o == $past(s.ls_tx_buffer_ctrl[9:0]))
      else $error("programmed sync code not used");
   skew_limit_a: assert property (s.skew_cnt[0][0] <= 3'h4)
      else $error("skew window ran past four bytes");

endmodule : lane_deskew_marker_config

// [pkg/lane_deskew_defines.svh]
/*
 Register addresses, field positions, reset values and fixed counts
 of the lane deskew and marker configuration block.
 Assumes it is included by its bare name, once or more.
*/
`ifndef LANE_DESKEW_DEFINES_SVH
`define LANE_DESKEW_DEFINES_SVH

`define ADDR_DESKEW_GROUPS    5'h16
`define ADDR_MARKER_GEN       5'h17
`define ADDR_RX_MARKER        5'h18
`define ADDR_TX_BUFFER        5'h19
`define ADDR_ALIGN_STATUS     5'h1A

`define RST_DESKEW_GROUPS     16'h0000
`define RST_MARKER_GEN        16'h02BC
`define RST_RX_MARKER         16'h0CC8
`define RST_TX_BUFFER         16'h02BC

`define DESKEW_WR_MASK        16'h7777
`define POS_TX_LOWER_SEL      0
`define POS_RX_LOWER_SEL      4
`define POS_TX_UPPER_SEL      8
`define POS_RX_UPPER_SEL      12
`define POS_MARKER_SEL        12
`define POS_MARKER_ENABLE     11
`define POS_DEPTH_SEL         13
`define POS_WATERMARK_SEL     11
`define POS_SYNC_OVERRIDE     10
`define POS_STATUS_LOW        8

`define MARKER_CRC_VALUE      32'hFE00_00FE
`define MAX_SKEW_BYTES        3'h4
`define BUFFER_DEPTH          8

`endif

// [pkg/lane_deskew_pkg.sv]
/*
 Types shared by the lane deskew and marker configuration block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package lane_deskew_pkg;

   typedef struct packed {
      logic [4:0]  addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } reg_req_t;

   // Up to two independent lane sets per group of four
   typedef struct packed {
      logic [3:0] set_b;
      logic [3:0] set_a;
   } lane_sets_t;

endpackage : lane_deskew_pkg

// [testbench/lane_deskew_marker_config_test.sv]
/*
 Self-checking bench of the lane deskew and marker configuration block.
 Assumes the design package, defines header and lane sink model.
*/
`timescale 1ns/1ps
`include "lane_deskew_defines.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %s exp %h got %h", n, e, g); end end

module lane_deskew_marker_config_test;
   import lane_deskew_pkg::*;
   localparam logic [9:0] BASE = 10'h0155;
   logic clk_i = 0, rst_i = 1, hold = 1, slow = 0, lsm = 0, lsl = 0, ilv = 1;
   logic tx_valid = 0, tx_ready, lane_valid, lane_ready, wm, got, det;
   reg_req_t req = '0;
   logic [3:0][3:0] seen = '0;
   logic [9:0] tx_data = '0, lane_data, got_data, sync, ew;
   logic [15:0] rdata, er, d;
   logic [7:0] mlane;
   logic [31:0] crc, rng = 32, rv;
   logic [3:0] m;
   logic [2:0] msel;
   logic [15:0] exp_rd[$];
   logic [9:0] exp_q[$];
   int bad_count = 0, tests_run = 0, n;
   int pos[4] = '{0, 8, 4, 12};

   initial begin
      forever #50 clk_i = ~clk_i;
   end

   lane_deskew_marker_config #(.BASE_SYNC(BASE)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
      .marker_seen_i(seen), .low_speed_marker_enable_i(lsm),
      .low_speed_signal_loss_enable_i(lsl), .rx_bitwise_interleave_i(ilv),
      .marker_lane_o(mlane), .marker_crc_o(crc), .rx_marker_detect_active_o(det),
      .rx_marker_sel_o(msel), .sync_code_o(sync), .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready), .tx_data_i(tx_data), .lane_valid_o(lane_valid),
      .lane_ready_i(lane_ready), .lane_data_o(lane_data), .tx_watermark_o(wm));

   lane_sink_model #(.W(10)) sink (
      .clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .slow_i(slow),
      .lane_valid_i(lane_valid), .lane_data_i(lane_data), .lane_ready_o(lane_ready),
      .got_o(got), .got_data_o(got_data));

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : xs

   function automatic logic [3:0] set_of(input int c);
      case (c)
         1, 5: return 4'h3;
         2: return 4'h7;
         3, 7: return 4'hF;
         4: return 4'hC;
         default: return 4'h0;
      endcase
   endfunction : set_of

   task tick(input int k);
      repeat (k) @(negedge clk_i);
   endtask : tick

   task wr(input logic [4:0] a, input logic [15:0] v);
      @(negedge clk_i);
      req.addr = a;
      req.wdata = v;
      req.wr = 1;
      @(negedge clk_i);
      req.wr = 0;
   endtask : wr

   task rd(input logic [4:0] a, input logic [15:0] e);
      @(negedge clk_i);
      req.addr = a;
      req.rd = 1;
      exp_rd.push_back(e);
      @(negedge clk_i);
      req.rd = 0;
   endtask : rd

   // Pushes words until the buffer refuses; valid is raised only while ready shows
   task fill(output int k);
      k = 0;
      for (int i = 0; i < 20; i++) begin
         @(negedge clk_i);
         if (tx_ready !== 1'b1) begin
            tx_valid = 0;
            return;
         end
         rv = xs();
         tx_valid = 1;
         tx_data = rv[9:0];
         @(posedge clk_i);
         exp_q.push_back(tx_data);
         k++;
      end
      bad_count++;
      results();
   endtask : fill

   task drain();
      for (int i = 0; i < 100 && exp_q.size() != 0; i++) @(negedge clk_i);
      tick(3);
      if (exp_q.size() != 0) begin
         bad_count++;
         results();
      end
   endtask : drain

   task results();
      if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results

   always @(posedge clk_i) begin
      if (req.rd === 1'b1) begin
         er = exp_rd.pop_front();
         @(negedge clk_i);
         `CHK("rdata", er, rdata)
      end
   end

   always @(posedge clk_i) begin
      if (got === 1'b1) begin
         ew = exp_q.size() != 0 ? exp_q.pop_front() : ~got_data;
         `CHK("lane_data", ew, got_data)
      end
   end

   initial begin
      tick(12);
      rst_i = 0;
      tick(2);
      `CHK("mlane", 8'h00, mlane)
      `CHK("crc", 32'hFE00_00FE, crc)
      `CHK("sync", BASE, sync)
      `CHK("det", 1'b1, det)
      `CHK("msel", 3'h0, msel)
      rd(`ADDR_DESKEW_GROUPS, 16'h0000);
      rd(`ADDR_MARKER_GEN, 16'h02BC);
      rd(`ADDR_RX_MARKER, 16'h0CC8);
      rd(`ADDR_TX_BUFFER, 16'h02BC);
      rd(5'h1F, 16'h0000);
      wr(`ADDR_DESKEW_GROUPS, 16'hFFFF);
      rd(`ADDR_DESKEW_GROUPS, 16'h7777);
      wr(`ADDR_ALIGN_STATUS, 16'hFFFF);
      rd(`ADDR_ALIGN_STATUS, 16'h0000);
      for (int u = 0; u < 4; u++) begin
         for (int c = 0; c < 8; c++) begin
            m = set_of(c);
            wr(`ADDR_DESKEW_GROUPS, 16'(c) << pos[u]);
            @(negedge clk_i);
            seen[u] = (m == 4'h0) ? 4'hF : m;
            @(negedge clk_i);
            seen[u] = 4'h0;
            rd(`ADDR_ALIGN_STATUS, m == 4'h0 ? 16'h0000 : 16'h0100 << u);
            rd(`ADDR_ALIGN_STATUS, 16'h0000);
         end
      end
      // Rx upper now holds code 111, the second spelling of all four lanes
      for (int g = 4; g <= 6; g += 2) begin
         @(negedge clk_i);
         seen[3] = 4'h1;
         @(negedge clk_i);
         seen[3] = 4'h0;
         tick(g - 1);
         seen[3] = 4'hE;
         @(negedge clk_i);
         seen[3] = 4'h0;
         rd(`ADDR_ALIGN_STATUS, g == 4 ? 16'h0800 : 16'h0000);
      end
      for (int s = 0; s < 8; s++) begin
         d = 16'h0ABC | (16'(s) << 12);
         wr(`ADDR_MARKER_GEN, d);
         tick(1);
         `CHK("mlane", 8'h01 << s, mlane)
         rd(`ADDR_MARKER_GEN, d);
      end
      wr(`ADDR_MARKER_GEN, 16'h52BC);
      tick(1);
      `CHK("mlane", 8'h00, mlane)
      lsm = 1;
      tick(2);
      `CHK("mlane", 8'h00, mlane)
      lsl = 1;
      tick(2);
      `CHK("mlane", 8'h20, mlane)
      rv = xs();
      wr(`ADDR_RX_MARKER, 16'h0CC8 | (16'(rv[2:0]) << 12));
      tick(1);
      `CHK("msel", rv[2:0], msel)
      `CHK("det", 1'b1, det)
      ilv = 0;
      tick(2);
      `CHK("det", 1'b0, det)
      ilv = 1;
      wr(`ADDR_RX_MARKER, 16'h04C8);
      tick(1);
      `CHK("det", 1'b0, det)
      // Target lane of the override is taken as already chosen
      rv = xs();
      wr(`ADDR_TX_BUFFER, 16'h0400 | 16'(rv[9:0]));
      tick(1);
      `CHK("sync", rv[9:0], sync)
      wr(`ADDR_TX_BUFFER, 16'(rv[9:0]));
      tick(1);
      `CHK("sync", BASE, sync)
      wr(`ADDR_TX_BUFFER, 16'h0800);
      fill(n);
      `CHK("fill", 8, n)
      tick(1);
      `CHK("wm", 1'b1, wm)
      slow = 1;
      hold = 0;
      drain();
      `CHK("wm", 1'b0, wm)
      hold = 1;
      wr(`ADDR_TX_BUFFER, 16'hB000);
      fill(n);
      `CHK("fill", 5, n)
      tick(1);
      `CHK("wm", 1'b0, wm)
      slow = 0;
      hold = 0;
      drain();
      results();
   end
endmodule : lane_deskew_marker_config_test

// [testbench/lane_sink_model.sv]
/*
 Lane-side sink of the transmit buffer: takes words on valid and ready.
 Assumes lane valid and data change only on rising edges of clk_i.
*/
`timescale 1ns/1ps
module lane_sink_model #(
   parameter int W = 10
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         hold_i,
   input  wire logic         slow_i,
   input  wire logic         lane_valid_i,
   input  wire logic [W-1:0] lane_data_i,
   output logic              lane_ready_o,
   output logic              got_o,
   output logic [W-1:0]      got_data_o
);
   logic [1:0] phase;
   // Slow mode takes one word in three, so the buffer sees back-pressure
   always @(posedge clk_i) begin
      got_o <= lane_valid_i & lane_ready_o & !rst_i;
      got_data_o <= lane_data_i;
      phase <= (rst_i || phase == 2'h2) ? 2'h0 : phase + 2'h1;
      lane_ready_o <= !rst_i && !hold_i && (!slow_i || phase == 2'h0);
   end
endmodule : lane_sink_model
